// [logic/jtap_pkg.sv]
// Operation
// - State advances on TMS at TCK rise
// - TAP state times capture, shift, update
// - TAP state picks instruction or data side
// - Current instruction selects the data chain
// - EXTEST, INTEST touch no chain
// - Unknown instruction codes act as BYPASS
// - Low test reset forces, holds Test-Logic-Reset
// - Power-on reset forces Test-Logic-Reset
// - Test-Logic-Reset loads IDCODE instruction
// - Five TMS-high clocks reach Test-Logic-Reset
// - Stopped TCK keeps state and registers
// - TDI sampled on rise, routed to chain
// - TDO changes on falling TCK edge
// - TDO from chain, undriven outside shifting
// - Chains capture, shift, update by state
// - Four-bit instruction chain with update register
// - Instruction codes decode, others as BYPASS
// - BYPASS is one shift stage
package jtap_pkg;

    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int DAP_W = 35;
    localparam int BS_W = 16;
    localparam int BUF_DEPTH = 2;

    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_INTEST = 4'h1;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
    localparam logic [IR_W-1:0] IR_ABORT = 4'h8;
    localparam logic [IR_W-1:0] IR_DPACC = 4'ha;
    localparam logic [IR_W-1:0] IR_APACC = 4'hb;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'he;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_RESET = IR_IDCODE;
    // Fixed 01 in the low bits lets a host check chain integrity
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    // Arbitrary identity value, bit 0 set as the scan convention needs
    localparam logic [ID_W-1:0] IDCODE_DEF = 32'h0a5c_3e01;
    localparam logic [2:0] TMS_RESET_CNT = 3'h5;

    typedef enum logic [3:0] {
        TAP_TLR = 4'b1111,
        TAP_RTI = 4'b1100,
        TAP_SEL_DR = 4'b0111,
        TAP_CAP_DR = 4'b0110,
        TAP_SH_DR = 4'b0010,
        TAP_EX1_DR = 4'b0001,
        TAP_PAU_DR = 4'b0011,
        TAP_EX2_DR = 4'b0000,
        TAP_UPD_DR = 4'b0101,
        TAP_SEL_IR = 4'b0100,
        TAP_CAP_IR = 4'b1110,
        TAP_SH_IR = 4'b1010,
        TAP_EX1_IR = 4'b1001,
        TAP_PAU_IR = 4'b1011,
        TAP_EX2_IR = 4'b1000,
        TAP_UPD_IR = 4'b1101
    } jtap_state_e;

    typedef enum logic [2:0] {
        CH_BYP = 3'b000,
        CH_ID = 3'b001,
        CH_BS = 3'b010,
        CH_DAP = 3'b011,
        CH_NONE = 3'b100
    } jtap_chain_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jtap_pins_s;

    typedef struct packed {
        logic [IR_W-1:0] instr;
        logic [DAP_W-1:0] data;
    } jtap_dbg_s;

    function automatic jtap_chain_e jtap_chain(input logic [IR_W-1:0] ir);
        jtap_chain_e c;
        c = CH_BYP;
        if (ir == IR_EXTEST || ir == IR_INTEST) begin
            c = CH_NONE;
        end else if (ir == IR_SAMPLE) begin
            c = CH_BS;
        end else if (ir == IR_IDCODE) begin
            c = CH_ID;
        end else if (ir == IR_ABORT || ir == IR_DPACC || ir == IR_APACC) begin
            c = CH_DAP;
        end
        return c;
    endfunction

endpackage

// [logic/jtap_sync.sv]
`timescale 1ns/1ps
module jtap_sync (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Pins in, synchronised out
    input wire jtap_pkg::jtap_pins_s d_i,
    output jtap_pkg::jtap_pins_s q_o
);
    import jtap_pkg::*;

    jtap_pins_s meta_r;
    jtap_pins_s meta_nxt;
    jtap_pins_s sync_r;
    jtap_pins_s sync_nxt;

    always_comb begin
        meta_nxt = d_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // TCK, TMS, TDI at idle levels, so no false TCK edge follows reset
            meta_r <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
            sync_r <= '{tck: 1'b1, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign q_o = sync_r;

endmodule

// [logic/jtap_buf.sv]
`timescale 1ns/1ps
module jtap_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic in_ready_r, out_valid_r;
    logic push, pop;

    always_comb begin
        push = in_valid_i & in_ready_r;
        pop = out_valid_r & out_ready_i;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b0;
            out_valid_r <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            in_ready_r <= (cnt_nxt != FULL);
            out_valid_r <= (cnt_nxt != '0);
        end
    end

    // Storage needs no reset; valid flags guard it
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    assign in_ready_o = in_ready_r;
    assign out_valid_o = out_valid_r;
    assign out_data_o = mem_r[rd_r];

endmodule

// [logic/jtap_top.sv]
`timescale 1ns/1ps
module jtap_top #(
    parameter int BSW = jtap_pkg::BS_W,
    parameter logic [jtap_pkg::ID_W-1:0] IDCODE_VAL = jtap_pkg::IDCODE_DEF
) (
    // Clock and power-on reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Test port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // Boundary chain
    input wire logic [BSW-1:0] bs_capture_i,
    output logic [BSW-1:0] bs_update_o,
    output logic extest_o,
    output logic intest_o,
    // Debug access words
    input wire logic [jtap_pkg::DAP_W-1:0] dap_rdata_i,
    output logic dbg_valid_o,
    input wire logic dbg_ready_i,
    output jtap_pkg::jtap_dbg_s dbg_word_o,
    // Observation
    output jtap_pkg::jtap_state_e tap_state_o
);
    import jtap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    jtap_pins_s pins_raw, pins;
    logic tck_q_r, tck_q_nxt;
    logic rise_pend_r, rise_pend_nxt;
    logic fall_pend_r, fall_pend_nxt;
    logic tms_l_r, tms_l_nxt;
    logic tdi_l_r, tdi_l_nxt;
    logic do_rise, do_fall, stall, trst_ok;

    assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i, trst_n: trst_n_i};

    jtap_sync u_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .d_i(pins_raw),
        .q_o(pins)
    );

    assign trst_ok = pins.trst_n;

    // A pending rising edge waits while a debug word cannot enter the buffer; a pending fall waits behind it
    always_comb begin
        tck_q_nxt = pins.tck;
        rise_pend_nxt = rise_pend_r;
        fall_pend_nxt = fall_pend_r;
        tms_l_nxt = tms_l_r;
        tdi_l_nxt = tdi_l_r;
        do_rise = rise_pend_r & ~stall;
        do_fall = fall_pend_r & ~rise_pend_r;
        if (do_rise) begin
            rise_pend_nxt = 1'b0;
        end
        if (do_fall) begin
            fall_pend_nxt = 1'b0;
        end
        if (pins.tck && !tck_q_r) begin
            rise_pend_nxt = 1'b1;
            tms_l_nxt = pins.tms;
            tdi_l_nxt = pins.tdi;
        end
        if (!pins.tck && tck_q_r) begin
            fall_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tck_q_r <= 1'b1;
            rise_pend_r <= 1'b0;
            fall_pend_r <= 1'b0;
            tms_l_r <= 1'b1;
            tdi_l_r <= 1'b1;
        end else begin
            tck_q_r <= tck_q_nxt;
            rise_pend_r <= rise_pend_nxt;
            fall_pend_r <= fall_pend_nxt;
            tms_l_r <= tms_l_nxt;
            tdi_l_r <= tdi_l_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    jtap_state_e state_r, state_nxt;

    function automatic jtap_state_e tap_next(input jtap_state_e s, input logic m);
        jtap_state_e n;
        n = s;
        case (s)
            TAP_TLR: n = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: n = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: n = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: n = m ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: n = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_RTI;
            default: n = TAP_TLR;
        endcase
        return n;
    endfunction

    // Test reset acts between clock edges, independent of TCK
    always_comb begin
        state_nxt = state_r;
        if (!trst_ok) begin
            state_nxt = TAP_TLR;
        end else if (do_rise) begin
            state_nxt = tap_next(state_r, tms_l_r);
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= TAP_TLR;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [IR_W-1:0] ir_sr_r, ir_sr_nxt, ir_r, ir_nxt;
    logic byp_r, byp_nxt;
    logic [ID_W-1:0] id_sr_r, id_sr_nxt;
    logic [BSW-1:0] bs_sr_r, bs_sr_nxt, bs_upd_r, bs_upd_nxt;
    logic [DAP_W-1:0] dap_sr_r, dap_sr_nxt;
    logic push_r, push_nxt;
    jtap_dbg_s push_word_r, push_word_nxt;
    jtap_chain_e chain;
    logic buf_ready;

    assign chain = jtap_chain(ir_r);
    assign stall = push_r & ~buf_ready;

    always_comb begin
        ir_sr_nxt = ir_sr_r;
        ir_nxt = ir_r;
        byp_nxt = byp_r;
        id_sr_nxt = id_sr_r;
        bs_sr_nxt = bs_sr_r;
        bs_upd_nxt = bs_upd_r;
        dap_sr_nxt = dap_sr_r;
        push_nxt = push_r & ~buf_ready;
        push_word_nxt = push_word_r;
        if (do_rise) begin
            case (state_r)
                TAP_CAP_IR: ir_sr_nxt = IR_CAPTURE;
                TAP_SH_IR: ir_sr_nxt = {tdi_l_r, ir_sr_r[IR_W-1:1]};
                TAP_UPD_IR: ir_nxt = ir_sr_r;
                TAP_CAP_DR: begin
                    case (chain)
                        CH_BYP: byp_nxt = 1'b0;
                        CH_ID: id_sr_nxt = IDCODE_VAL;
                        CH_BS: bs_sr_nxt = bs_capture_i;
                        CH_DAP: dap_sr_nxt = dap_rdata_i;
                        default: ;
                    endcase
                end
                TAP_SH_DR: begin
                    case (chain)
                        CH_BYP: byp_nxt = tdi_l_r;
                        CH_ID: id_sr_nxt = {tdi_l_r, id_sr_r[ID_W-1:1]};
                        CH_BS: bs_sr_nxt = {tdi_l_r, bs_sr_r[BSW-1:1]};
                        CH_DAP: dap_sr_nxt = {tdi_l_r, dap_sr_r[DAP_W-1:1]};
                        default: ;
                    endcase
                end
                TAP_UPD_DR: begin
                    if (chain == CH_BS) begin
                        bs_upd_nxt = bs_sr_r;
                    end else if (chain == CH_DAP) begin
                        push_nxt = 1'b1;
                        push_word_nxt = '{instr: ir_r, data: dap_sr_r};
                    end
                end
                default: ;
            endcase
        end
        if (state_nxt == TAP_TLR) begin
            ir_nxt = IR_RESET;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ir_sr_r <= IR_CAPTURE;
            ir_r <= IR_RESET;
            byp_r <= 1'b0;
            id_sr_r <= '0;
            bs_sr_r <= '0;
            bs_upd_r <= '0;
            dap_sr_r <= '0;
            push_r <= 1'b0;
            push_word_r <= '0;
        end else begin
            ir_sr_r <= ir_sr_nxt;
            ir_r <= ir_nxt;
            byp_r <= byp_nxt;
            id_sr_r <= id_sr_nxt;
            bs_sr_r <= bs_sr_nxt;
            bs_upd_r <= bs_upd_nxt;
            dap_sr_r <= dap_sr_nxt;
            push_r <= push_nxt;
            push_word_r <= push_word_nxt;
        end
    end

    jtap_buf #(
        .W($bits(jtap_dbg_s)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .in_valid_i(push_r),
        .in_ready_o(buf_ready),
        .in_data_i(push_word_r),
        .out_valid_o(dbg_valid_o),
        .out_ready_i(dbg_ready_i),
        .out_data_o(dbg_word_o)
    );

    ////////////////////////////////////////////////////////////////////////
    logic tdo_r, tdo_nxt, oe_r, oe_nxt;
    logic extest_r, extest_nxt, intest_r, intest_nxt;

    always_comb begin
        tdo_nxt = tdo_r;
        oe_nxt = oe_r;
        extest_nxt = (ir_r == IR_EXTEST);
        intest_nxt = (ir_r == IR_INTEST);
        if (!trst_ok) begin
            tdo_nxt = 1'b0;
            oe_nxt = 1'b0;
        end else if (do_fall) begin
            tdo_nxt = 1'b0;
            oe_nxt = 1'b0;
            if (state_r == TAP_SH_IR) begin
                tdo_nxt = ir_sr_r[0];
                oe_nxt = 1'b1;
            end else if (state_r == TAP_SH_DR && chain != CH_NONE) begin
                oe_nxt = 1'b1;
                case (chain)
                    CH_ID: tdo_nxt = id_sr_r[0];
                    CH_BS: tdo_nxt = bs_sr_r[0];
                    CH_DAP: tdo_nxt = dap_sr_r[0];
                    default: tdo_nxt = byp_r;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tdo_r <= 1'b0;
            oe_r <= 1'b0;
            extest_r <= 1'b0;
            intest_r <= 1'b0;
        end else begin
            tdo_r <= tdo_nxt;
            oe_r <= oe_nxt;
            extest_r <= extest_nxt;
            intest_r <= intest_nxt;
        end
    end

    assign tdo_o = tdo_r;
    assign tdo_oe_o = oe_r;
    assign extest_o = extest_r;
    assign intest_o = intest_r;
    assign bs_update_o = bs_upd_r;
    assign tap_state_o = state_r;

    ////////////////////////////////////////////////////////////////////////
    // Helper: run of TMS-high rising edges, saturating
    logic [2:0] tms_cnt_r, tms_cnt_nxt;

    always_comb begin
        tms_cnt_nxt = tms_cnt_r;
        if (do_rise) begin
            if (!tms_l_r) begin
                tms_cnt_nxt = '0;
            end else if (tms_cnt_r != TMS_RESET_CNT) begin
                tms_cnt_nxt = tms_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tms_cnt_r <= '0;
        end else begin
            tms_cnt_r <= tms_cnt_nxt;
        end
    end

    property p_trst_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        !trst_ok |=> (state_r == TAP_TLR) && !oe_r;
    endproperty
    a_trst_hold: assert property (p_trst_hold) else $error("test reset not honoured");

    property p_no_edge_no_move;
        @(posedge mclk_i) disable iff (!rstn_i)
        (trst_ok && !do_rise) |=> $stable(state_r) && $stable(ir_r) && $stable(byp_r);
    endproperty
    a_no_edge_no_move: assert property (p_no_edge_no_move) else $error("state moved without edge");

    property p_tms_step;
        @(posedge mclk_i) disable iff (!rstn_i)
        (trst_ok && do_rise && state_r == TAP_RTI) |=> state_r == (tms_l_r ? TAP_SEL_DR : TAP_RTI);
    endproperty
    a_tms_step: assert property (p_tms_step) else $error("wrong step from idle");

    property p_five_ones;
        @(posedge mclk_i) disable iff (!rstn_i)
        (tms_cnt_r == TMS_RESET_CNT) |-> state_r == TAP_TLR;
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("five TMS ones missed reset");

    property p_idcode_default;
        @(posedge mclk_i) disable iff (!rstn_i)
        (state_r == TAP_TLR) |=> ir_r == IR_IDCODE;
    endproperty
    a_idcode_default: assert property (p_idcode_default) else $error("no IDCODE in reset");

    property p_ir_update;
        @(posedge mclk_i) disable iff (!rstn_i)
        (trst_ok && do_rise && state_r == TAP_UPD_IR) |=> ir_r == $past(ir_sr_r);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

    property p_tdo_on_fall;
        @(posedge mclk_i) disable iff (!rstn_i)
        $rose(oe_r) |-> $past(do_fall) && $past(state_r == TAP_SH_IR || state_r == TAP_SH_DR);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("TDO driven off shift fall");

    property p_bypass_stage;
        @(posedge mclk_i) disable iff (!rstn_i)
        (trst_ok && do_rise && state_r == TAP_SH_DR && chain == CH_BYP) |=> byp_r == $past(tdi_l_r);
    endproperty
    a_bypass_stage: assert property (p_bypass_stage) else $error("bypass stage wrong");

    property p_extest_quiet;
        @(posedge mclk_i) disable iff (!rstn_i)
        (chain == CH_NONE && state_r != TAP_UPD_IR) |=> $stable(bs_sr_r) && $stable(bs_upd_r);
    endproperty
    a_extest_quiet: assert property (p_extest_quiet) else $error("chain moved in EXTEST/INTEST");

endmodule

// [testbench/jtap_host.sv]
`timescale 1ns/1ps
module jtap_host (
    // Pins toward the port
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    // Pins from the port
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    // Released TDO floats up to its pull-up
    wire logic line = tdo_oe_i ? tdo_i : 1'b1;

    initial begin
        tck_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b1;
        trst_n_o = 1'b1;
    end

    // One 125 ns TCK period; TCK parks high between calls
    task automatic step(input logic m, input logic d, output logic q);
        tck_o = 1'b0;
        tms_o = m;
        tdi_o = d;
        #62.5;
        q = line;
        tck_o = 1'b1;
        #62.5;
    endtask
endmodule

// [testbench/jtap_top_bench.sv]
`timescale 1ns/1ps
module jtap_top_bench;
    import jtap_pkg::*;
    // Arbitrary identity value, bit 0 set
    localparam logic [ID_W-1:0] ID_VAL = 32'h5e1d_0c4b;
    localparam int LIMIT = 40000;
    logic mclk_i = 1'b0;
    logic rstn = 1'b0;
    logic dbg_ready = 1'b0;
    logic [BS_W-1:0] bs_cap = 16'hc3a5;
    logic [DAP_W-1:0] dap = 35'h5_9a3c_e17d;
    wire logic tck, tms, tdi, trst_n, tdo, oe, extest, intest, dbg_valid;
    wire logic [BS_W-1:0] bs_upd;
    jtap_dbg_s dbg_word;
    jtap_state_e st_o;
    jtap_dbg_s exp_q[$];
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    always #4 mclk_i = ~mclk_i;

    jtap_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
        .tdo_i(tdo), .tdo_oe_i(oe));

    jtap_top #(.BSW(BS_W), .IDCODE_VAL(ID_VAL)) uut (.mclk_i(mclk_i), .rstn_i(rstn),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo),
        .tdo_oe_o(oe), .bs_capture_i(bs_cap), .bs_update_o(bs_upd), .extest_o(extest),
        .intest_o(intest), .dap_rdata_i(dap), .dbg_valid_o(dbg_valid),
        .dbg_ready_i(dbg_ready), .dbg_word_o(dbg_word), .tap_state_o(st_o));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Sink: every taken word must be the oldest one expected
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (dbg_valid && dbg_ready) begin
            if (exp_q.size() == 0) begin
                chk("dbg_extra", 64'h1, 64'h0);
            end else begin
                chk("dbg_word", 64'(dbg_word), 64'(exp_q.pop_front()));
            end
        end
        if (cycles == LIMIT) begin
            fails++;
            wrap_up();
        end
    end

    task automatic st(input logic m, input logic d = 1'b0);
        logic q;
        host.step(m, d, q);
    endtask

    // From Run-Test/Idle through one shift, back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
            output logic [63:0] dout);
        dout = '0;
        st(1'b1);
        if (ir) st(1'b1);
        st(1'b0);
        st(1'b0);
        for (int i = 0; i < n; i++) host.step(i == n - 1, din[i], dout[i]);
        st(1'b1);
        st(1'b0);
    endtask

    task automatic load_ir(input logic [3:0] c);
        logic [63:0] d;
        scan(1'b1, IR_W, 64'(c), d);
        chk("ir_capture", 64'(d[3:0]), 64'(IR_CAPTURE));
    endtask

    task automatic drain;
        int n;
        n = 0;
        @(posedge mclk_i);
        dbg_ready <= 1'b1;
        while (exp_q.size() > 0 && n < 50) begin
            @(posedge mclk_i);
            n++;
        end
        @(posedge mclk_i);
        dbg_ready <= 1'b0;
        @(negedge mclk_i);
        chk("dbg_left", 64'(exp_q.size()), 64'h0);
        chk("dbg_empty", 64'(dbg_valid), 64'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_walk;
        logic m[22] = '{0, 1, 0, 0, 1, 0, 1, 0, 1, 1, 1, 1, 0, 0, 1, 0, 1, 1, 0, 1, 1, 1};
        jtap_state_e e[22] = '{TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
            TAP_PAU_DR, TAP_EX2_DR, TAP_SH_DR, TAP_EX1_DR, TAP_UPD_DR, TAP_SEL_DR,
            TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR,
            TAP_UPD_IR, TAP_RTI, TAP_SEL_DR, TAP_SEL_IR, TAP_TLR};
        for (int i = 0; i < 22; i++) begin
            st(m[i]);
            // Parked TCK must freeze everything
            if (i == 5) repeat (100) @(posedge mclk_i);
            chk("tap_state", 64'(st_o), 64'(e[i]));
            // One zero shifted over the capture value gives 0000
            if (i == 18) chk("extest", 64'(extest), 64'h1);
        end
        chk("extest_tlr", 64'(extest), 64'h0);
        st(1'b0);
    endtask

    task automatic t_codes;
        logic [63:0] din, d, x, cap;
        int l;
        din = 64'h0000_00b7_2d4e_9a61;
        for (int c = 0; c < 16; c++) begin
            load_ir(4'(c));
            chk("extest", 64'(extest), 64'(c == 0));
            chk("intest", 64'(intest), 64'(c == 1));
            l = 1;
            cap = '0;
            case (c)
                0, 1: l = 0;
                2: l = BS_W;
                8, 10, 11: l = DAP_W;
                14: l = ID_W;
                default: l = 1;
            endcase
            if (c == 2) cap = 64'(bs_cap);
            if (c == 14) cap = 64'(ID_VAL);
            if (l == DAP_W) cap = 64'(dap);
            if (l == DAP_W) exp_q.push_back(jtap_dbg_s'{4'(c), din[39:5]});
            x = '1;
            for (int i = 0; i < 40 && l > 0; i++) x[i] = i < l ? cap[i] : din[i - l];
            scan(1'b0, 40, din, d);
            chk("dr_out", 64'(d[39:0]), 64'(x[39:0]));
            if (c == 2) chk("bs_update", 64'(bs_upd), 64'(din[39:24]));
            if (c == 10) begin
                repeat (20) @(posedge mclk_i);
                chk("dbg_held", 64'(dbg_valid), 64'h1);
            end
            if (c >= 10 && c <= 11) drain();
            din = din + 64'h0000_0013_5791_3579;
        end
    endtask

    task automatic t_tms;
        logic [63:0] d;
        load_ir(IR_BYPASS);
        st(1'b1);
        st(1'b0);
        st(1'b0);
        repeat (4) st(1'b1);
        chk("tap_state", 64'(st_o), 64'(TAP_SEL_IR));
        st(1'b1);
        chk("tap_state", 64'(st_o), 64'(TAP_TLR));
        st(1'b0);
        scan(1'b0, ID_W, '0, d);
        chk("idcode", 64'(d[31:0]), 64'(ID_VAL));
    endtask

    task automatic t_rst(input logic por);
        logic [63:0] d;
        load_ir(IR_BYPASS);
        st(1'b1);
        st(1'b0);
        st(1'b0);
        st(1'b0, 1'b1);
        chk("oe_shift", 64'(oe), 64'h1);
        @(posedge mclk_i);
        if (por) rstn <= 1'b0;
        else host.trst_n_o <= 1'b0;
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("rst_state", 64'(st_o), 64'(TAP_TLR));
        chk("rst_oe", 64'(oe), 64'h0);
        st(1'b0);
        st(1'b0);
        chk("rst_hold", 64'(st_o), 64'(TAP_TLR));
        @(posedge mclk_i);
        rstn <= 1'b1;
        host.trst_n_o <= 1'b1;
        repeat (8) @(posedge mclk_i);
        st(1'b0);
        scan(1'b0, ID_W, '0, d);
        chk("idcode", 64'(d[31:0]), 64'(ID_VAL));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("por_state", 64'(st_o), 64'(TAP_TLR));
        chk("por_oe", 64'(oe), 64'h0);
        @(posedge mclk_i);
        rstn <= 1'b1;
        repeat (6) @(posedge mclk_i);
        t_walk();
        $display("test walk done");
        t_codes();
        $display("test codes done");
        t_tms();
        $display("test tms_reset done");
        t_rst(1'b0);
        $display("test trst done");
        t_rst(1'b1);
        $display("test por done");
        wrap_up();
    end
endmodule
